//--- core/aes_stage.sv
// Accidental energizing protection stage with AHB-Lite registers
// Notes on behaviour
// - Takes three phase currents and four voltage channels refreshed every 5 ms.
// - Operating mode On, Blocked, Test, Test/Blocked or Off; default On.
// - Forced status Normal, Start, Trip or Blocked; Normal passes computed status.
// - Mode and forcing are static, untouched by setting group selection.
// - Pick-up settings come from the active group, changeable while running.
// - Voltage under limit for the activation delay arms start.
// - Voltage above limit keeps start for the release delay, then clears.
// - Start armed and every phase current above limit trips the stage.
// - Trip still possible while the release delay is counting.
// - Undervoltage limit 0.00 to 99.00 percent nominal, default 50.00.
// - Block sampled each program cycle; block at pick-up gives blocked, not start.
// - Block on active start clears start and runs release timing.
// - On and off events for start, trip, block with counters.
`timescale 1ns/1ps
module aes_stage
  import aes_pkg::*;
#(
  parameter int CYCLE_CLKS = PROG_CYCLE_CLKS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [MEAS_W-1:0] cur_l1,
  input wire logic [MEAS_W-1:0] cur_l2,
  input wire logic [MEAS_W-1:0] cur_l3,
  input wire logic [MEAS_W-1:0] volt_u1,
  input wire logic [MEAS_W-1:0] volt_u2,
  input wire logic [MEAS_W-1:0] volt_u3,
  input wire logic [MEAS_W-1:0] volt_u4,
  input wire logic block_in,
  input wire logic [GSEL_W-1:0] group_sel,
  output logic stage_start,
  output logic stage_trip,
  output logic stage_blocked,
  output logic irq,
  output logic evt_valid,
  output logic [EV_N-1:0] evt_flags,
  output logic [31:0] evt_stamp
);
  typedef struct packed {
    logic [31:0] div;
    logic tick;
    aes_state_t st;
    logic [2:0] mode;
    logic [1:0] force_sel;
    logic [NUM_GROUPS-1:0][3:0][TMR_W-1:0] set;
    logic [EV_N-1:0] ist;
    logic [EV_N-1:0] imask;
    logic [1:0] evsel;
    logic s_start;
    logic s_trip;
    logic s_blk;
    logic [31:0] stamp;
    logic ev_v;
    logic [EV_N-1:0] ev_f;
    logic [2:0] cnt_inc;
    logic [2:0] cnt_clr;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } aes_stage_t;

  localparam logic [31:0] DIV_LAST = 32'(CYCLE_CLKS - 1);

  aes_stage_t r;
  aes_stage_t next_r;
  logic [MEAS_W-1:0] v_a, v_b, vmax, i_a, imin, ulim, ilim;
  logic under, all_over, blk, act_done, rel_done, test_mode, mode_off;
  logic raw_trip;
  logic [CNT_W-1:0] cnt_start, cnt_trip, cnt_block;

  generate
    if (CYCLE_CLKS < 1 || NUM_GROUPS != (1 << GSEL_W)) begin : g_chk
      $error("Unsupported cycle length or group count");
    end
  endgenerate

  // Highest voltage channel and lowest phase current
  assign v_a = (volt_u1 > volt_u2) ? volt_u1 : volt_u2;
  assign v_b = (volt_u3 > volt_u4) ? volt_u3 : volt_u4;
  assign vmax = (v_a > v_b) ? v_a : v_b;
  assign i_a = (cur_l1 < cur_l2) ? cur_l1 : cur_l2;
  assign imin = (i_a < cur_l3) ? i_a : cur_l3;
  assign ulim = r.set[group_sel][F_ULIM][MEAS_W-1:0];
  assign ilim = r.set[group_sel][F_ILIM][MEAS_W-1:0];
  assign under = vmax < ulim;
  assign all_over = imin > ilim;
  assign mode_off = !(r.mode inside {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED});
  assign test_mode = (r.mode == MODE_TEST) || (r.mode == MODE_TEST_BLOCKED);
  assign blk = block_in || (r.mode == MODE_BLOCKED) || (r.mode == MODE_TEST_BLOCKED);
  assign raw_trip = ((r.st == ST_ARMED) || (r.st == ST_RELEASING)) && all_over && !blk;

  aes_delay_timer #(.W(TMR_W)) u_act (
    .ref_clk(ref_clk), .resetn(resetn), .tick(r.tick), .run(r.st == ST_ARMING),
    .limit(r.set[group_sel][F_TACT]), .done(act_done)
  );
  aes_delay_timer #(.W(TMR_W)) u_rel (
    .ref_clk(ref_clk), .resetn(resetn), .tick(r.tick), .run(r.st == ST_RELEASING),
    .limit(r.set[group_sel][F_TREL]), .done(rel_done)
  );
  aes_event_counter #(.W(CNT_W)) u_cnt_start (
    .ref_clk(ref_clk), .resetn(resetn), .inc(r.cnt_inc[0]), .clr(r.cnt_clr[0]), .count(cnt_start)
  );
  aes_event_counter #(.W(CNT_W)) u_cnt_trip (
    .ref_clk(ref_clk), .resetn(resetn), .inc(r.cnt_inc[1]), .clr(r.cnt_clr[1]), .count(cnt_trip)
  );
  aes_event_counter #(.W(CNT_W)) u_cnt_block (
    .ref_clk(ref_clk), .resetn(resetn), .inc(r.cnt_inc[2]), .clr(r.cnt_clr[2]), .count(cnt_block)
  );

  always_comb begin
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;
    logic [7:0] woff;
    logic [31:0] rd;
    ev = '0;
    clr = '0;
    woff = '0;
    rd = '0;
    next_r = r;
    next_r.tick = 1'b0;
    next_r.ev_v = 1'b0;
    next_r.ev_f = '0;
    next_r.cnt_inc = '0;
    next_r.cnt_clr = '0;
    // Program cycle divider
    if (r.div == DIV_LAST) begin
      next_r.div = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 32'd1;
    end
    // Register writes in the data phase
    if (r.a_wr) begin
      woff = r.a_addr - GRP_BASE;
      unique case (r.a_addr)
        REG_CTRL: begin
          next_r.mode = hwdata[CTRL_MODE_LSB +: 3];
          next_r.force_sel = hwdata[CTRL_FORCE_LSB +: 2];
        end
        REG_IST: clr = hwdata[EV_N-1:0];
        REG_IMASK: next_r.imask = hwdata[EV_N-1:0];
        REG_EVSEL: next_r.evsel = hwdata[1:0];
        REG_CNT_CLR: next_r.cnt_clr = hwdata[2:0];
        default: begin
          if (r.a_addr >= GRP_BASE && woff < GRP_SPAN) begin
            next_r.set[woff[GRP_IDX_LSB +: GSEL_W]][woff[FLD_IDX_LSB +: 2]] = hwdata[TMR_W-1:0];
          end
        end
      endcase
    end
    // Stage evaluation once per program cycle
    if (r.tick) begin
      next_r.stamp = r.stamp + 32'd1;
      if (mode_off) begin
        next_r.st = ST_IDLE;
      end else begin
        unique case (r.st)
          ST_IDLE: if (under) next_r.st = ST_ARMING;
          ST_ARMING: begin
            if (!under) begin
              next_r.st = ST_IDLE;
            end else if (act_done) begin
              next_r.st = blk ? ST_BLOCKED : ST_ARMED;
            end
          end
          ST_ARMED: if (blk || !under) next_r.st = ST_RELEASING;
          ST_RELEASING: begin
            if (under && !blk) begin
              next_r.st = ST_ARMED;
            end else if (rel_done) begin
              next_r.st = ST_IDLE;
            end
          end
          ST_BLOCKED: begin
            if (!under) begin
              next_r.st = ST_IDLE;
            end else if (!blk) begin
              next_r.st = ST_ARMED;
            end
          end
        endcase
      end
      unique case (aes_force_t'(r.force_sel))
        FORCE_NORMAL: begin
          next_r.s_start = (next_r.st == ST_ARMED) || ((next_r.st == ST_RELEASING) && !blk);
          next_r.s_trip = raw_trip;
          next_r.s_blk = (next_r.st == ST_BLOCKED) || ((next_r.st == ST_RELEASING) && blk);
        end
        FORCE_START: {next_r.s_start, next_r.s_trip, next_r.s_blk} = 3'h4;
        FORCE_TRIP: {next_r.s_start, next_r.s_trip, next_r.s_blk} = 3'h6;
        FORCE_BLOCKED: {next_r.s_start, next_r.s_trip, next_r.s_blk} = 3'h1;
      endcase
      if (mode_off) begin
        {next_r.s_start, next_r.s_trip, next_r.s_blk} = 3'h0;
      end
      ev[EV_START_ON] = next_r.s_start && !r.s_start;
      ev[EV_START_OFF] = !next_r.s_start && r.s_start;
      ev[EV_TRIP_ON] = next_r.s_trip && !r.s_trip;
      ev[EV_TRIP_OFF] = !next_r.s_trip && r.s_trip;
      ev[EV_BLOCK_ON] = next_r.s_blk && !r.s_blk;
      ev[EV_BLOCK_OFF] = !next_r.s_blk && r.s_blk;
      next_r.cnt_inc = {ev[EV_BLOCK_ON], ev[EV_TRIP_ON], ev[EV_START_ON]};
      next_r.ev_f = ev & ((r.evsel[0] ? EV_ON_MASK : '0) | (r.evsel[1] ? EV_OFF_MASK : '0));
      next_r.ev_v = |next_r.ev_f;
    end
    // Sticky status, new event wins over clear
    next_r.ist = (r.ist & ~clr) | next_r.ev_f;
    // Register reads in the address phase
    if (hsel && hready && htrans[1]) begin
      next_r.a_wr = hwrite;
      next_r.a_addr = haddr[7:0];
      woff = haddr[7:0] - GRP_BASE;
      unique case (haddr[7:0])
        REG_CTRL: rd = 32'({r.force_sel, 1'b0, r.mode});
        REG_STATUS: rd = 32'({r.st, r.s_blk, r.s_trip, r.s_start});
        REG_IST: rd = 32'(r.ist);
        REG_IMASK: rd = 32'(r.imask);
        REG_EVSEL: rd = 32'(r.evsel);
        REG_CNT_START: rd = 32'(cnt_start);
        REG_CNT_TRIP: rd = 32'(cnt_trip);
        REG_CNT_BLOCK: rd = 32'(cnt_block);
        REG_STAMP: rd = r.stamp;
        default: begin
          if (haddr[7:0] >= GRP_BASE && woff < GRP_SPAN) begin
            rd = 32'(r.set[woff[GRP_IDX_LSB +: GSEL_W]][woff[FLD_IDX_LSB +: 2]]);
          end
        end
      endcase
      if (!hwrite) begin
        next_r.rdata = rd;
      end
    end else if (hready) begin
      next_r.a_wr = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.mode <= MODE_ON;
      r.force_sel <= FORCE_NORMAL;
      r.evsel <= EVSEL_RST;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        r.set[g][F_ULIM] <= ULIM_RST;
        r.set[g][F_ILIM] <= ILIM_RST;
        r.set[g][F_TACT] <= TACT_RST;
        r.set[g][F_TREL] <= TREL_RST;
      end
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign stage_start = r.s_start && !test_mode;
  assign stage_trip = r.s_trip && !test_mode;
  assign stage_blocked = r.s_blk;
  assign irq = |(r.ist & r.imask);
  assign evt_valid = r.ev_v;
  assign evt_flags = r.ev_f;
  assign evt_stamp = r.stamp;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_tick_once;
    r.tick |=> !r.tick;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("Cycle strobe longer than one clock");
  property p_arm;
    r.tick && !mode_off && r.st == ST_ARMING && under && act_done && !blk |=> r.st == ST_ARMED;
  endproperty
  a_arm: assert property (p_arm) else $error("Start not armed after delay");
  property p_release;
    r.tick && !mode_off && r.st == ST_ARMED && !under |=> r.st == ST_RELEASING;
  endproperty
  a_release: assert property (p_release) else $error("Start not held for release");
  property p_trip_needs_start;
    r.tick && r.force_sel == FORCE_NORMAL && !mode_off ##1 r.s_trip |-> $past(r.st) inside {ST_ARMED, ST_RELEASING};
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start) else $error("Trip without start");
  property p_release_trip;
    r.tick && r.st == ST_RELEASING && all_over && !blk && r.force_sel == FORCE_NORMAL && !mode_off |=> r.s_trip;
  endproperty
  a_release_trip: assert property (p_release_trip) else $error("No trip during release");
  property p_block_pickup;
    r.tick && r.st == ST_ARMING && under && act_done && blk && !mode_off |=> r.st == ST_BLOCKED ##1 !r.s_start;
  endproperty
  a_block_pickup: assert property (p_block_pickup) else $error("Start despite block");
  property p_block_active;
    r.tick && !mode_off && r.st == ST_ARMED && blk |=> r.st == ST_RELEASING;
  endproperty
  a_block_active: assert property (p_block_active) else $error("Block did not release start");
  property p_off_quiet;
    mode_off && r.tick |=> !r.s_start && !r.s_trip && !r.s_blk;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Output active in Off mode");
  property p_force_trip;
    r.tick && !mode_off && r.force_sel == FORCE_TRIP |=> r.s_trip && r.s_start;
  endproperty
  a_force_trip: assert property (p_force_trip) else $error("Forced trip ignored");
  property p_start_event;
    r.tick && r.evsel[0] && !r.s_start ##1 r.s_start |-> r.ev_v && r.ev_f[EV_START_ON];
  endproperty
  a_start_event: assert property (p_start_event) else $error("Missing start event");
endmodule : aes_stage

//--- core/aes_pkg.sv
// Shared constants and types of the accidental energizing stage
package aes_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYCLE_MS = 5;
  localparam int PROG_CYCLE_CLKS = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MEAS_W = 16;
  localparam int TMR_W = 19;
  localparam int CNT_W = 16;
  localparam int NUM_GROUPS = 2;
  localparam int GSEL_W = 1;
  localparam int EV_N = 6;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IST = 8'h08;
  localparam logic [7:0] REG_IMASK = 8'h0C;
  localparam logic [7:0] REG_EVSEL = 8'h10;
  localparam logic [7:0] REG_CNT_START = 8'h14;
  localparam logic [7:0] REG_CNT_TRIP = 8'h18;
  localparam logic [7:0] REG_CNT_BLOCK = 8'h1C;
  localparam logic [7:0] REG_CNT_CLR = 8'h20;
  localparam logic [7:0] REG_STAMP = 8'h24;
  localparam logic [7:0] GRP_BASE = 8'h40;
  localparam logic [7:0] GRP_SPAN = 8'h20;
  // Setting slots within a group, one word each
  localparam int F_ULIM = 0;
  localparam int F_ILIM = 1;
  localparam int F_TACT = 2;
  localparam int F_TREL = 3;
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FORCE_LSB = 4;
  localparam int GRP_IDX_LSB = 4;
  localparam int FLD_IDX_LSB = 2;
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_BLOCK_ON = 4;
  localparam int EV_BLOCK_OFF = 5;
  localparam logic [EV_N-1:0] EV_ON_MASK = 6'h15;
  localparam logic [EV_N-1:0] EV_OFF_MASK = 6'h2A;
  // Reset values: 50.00 %, 0.05 xIn, 5.000 s and 0.250 s in 5 ms cycles
  localparam logic [TMR_W-1:0] ULIM_RST = 19'h0_1388;
  localparam logic [TMR_W-1:0] ILIM_RST = 19'h0_0005;
  localparam logic [TMR_W-1:0] TACT_RST = 19'h0_03E8;
  localparam logic [TMR_W-1:0] TREL_RST = 19'h0_0032;
  localparam logic [1:0] EVSEL_RST = 2'h3;
  typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} aes_mode_t;
  typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} aes_force_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ARMING, ST_ARMED, ST_RELEASING, ST_BLOCKED} aes_state_t;
endpackage : aes_pkg

//--- core/aes_delay_timer.sv
// Definite time delay counter advanced by the program cycle enable
`timescale 1ns/1ps
module aes_delay_timer #(
  parameter int W = 19
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } aes_tmr_t;
  aes_tmr_t r;
  aes_tmr_t next_r;

  generate
    if (W < 1) begin : g_chk
      $error("Timer width must be positive");
    end
  endgenerate

  // Done on the tick that completes the count, so a delay of N ends N ticks after the state was entered
  assign done = run && (({1'b0, r.cnt} + {{W{1'b0}}, 1'b1}) >= {1'b0, limit});

  always_comb begin
    next_r = r;
    if (!run) begin
      next_r.cnt = '0;
    end else if (tick && !done) begin
      next_r.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : aes_delay_timer

//--- core/aes_event_counter.sv
// Saturating cumulative event counter with clear
`timescale 1ns/1ps
module aes_event_counter #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } aes_cnt_t;
  aes_cnt_t r;
  aes_cnt_t next_r;

  generate
    if (W < 1) begin : g_chk
      $error("Counter width must be positive");
    end
  endgenerate

  assign count = r.cnt;

  always_comb begin
    next_r = r;
    if (clr) begin
      next_r.cnt = W'(inc);
    end else if (inc && !(&r.cnt)) begin
      next_r.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : aes_event_counter

//--- tb/aes_meas_model.sv
// Measurement front end and blocking matrix model
`timescale 1ns/1ps
module aes_meas_model
  import aes_pkg::*;
(
  input wire logic ref_clk,
  output logic [MEAS_W-1:0] cur_l1,
  output logic [MEAS_W-1:0] cur_l2,
  output logic [MEAS_W-1:0] cur_l3,
  output logic [MEAS_W-1:0] volt_u1,
  output logic [MEAS_W-1:0] volt_u2,
  output logic [MEAS_W-1:0] volt_u3,
  output logic [MEAS_W-1:0] volt_u4,
  output logic block_in
);
  logic [MEAS_W-1:0] v_n, a_n, b_n, c_n;
  logic k_n;
  initial begin
    v_n = 16'h1770;
    a_n = 16'h0;
    b_n = 16'h0;
    c_n = 16'h0;
    k_n = 1'b0;
    {cur_l1, cur_l2, cur_l3, block_in} = '0;
    {volt_u1, volt_u2, volt_u3, volt_u4} = {4{16'h1770}};
  end
  task set(input logic [MEAS_W-1:0] v, a, b, c, input logic k);
    v_n = v;
    a_n = a;
    b_n = b;
    c_n = c;
    k_n = k;
  endtask : set
  // Three phases and four voltage channels, highest on channel two
  always @(posedge ref_clk) begin
    cur_l1 <= a_n;
    cur_l2 <= b_n;
    cur_l3 <= c_n;
    volt_u1 <= v_n >> 1;
    volt_u2 <= v_n;
    volt_u3 <= v_n >> 2;
    volt_u4 <= v_n >> 1;
    block_in <= k_n;
  end
endmodule : aes_meas_model

//--- tb/testbench.sv
// Self-checking bench of the accidental energizing stage
`timescale 1ns/1ps
module testbench;
  import aes_pkg::*;
  localparam int CC = 10;
  localparam int TA = 4;
  localparam int TR = 3;
  localparam logic [TMR_W-1:0] RV [4] = '{ULIM_RST, ILIM_RST, TACT_RST, TREL_RST};
  localparam logic [2:0] FX [3] = '{3'h1, 3'h3, 3'h4};
  logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp, block_in, irq, evt_valid;
  logic stage_start, stage_trip, stage_blocked;
  logic [31:0] haddr, hwdata, hrdata, rd, evt_stamp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [GSEL_W-1:0] group_sel;
  logic [MEAS_W-1:0] cur_l1, cur_l2, cur_l3, volt_u1, volt_u2, volt_u3, volt_u4;
  logic [EV_N-1:0] evt_flags;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n, m;

  aes_stage #(.CYCLE_CLKS(CC)) dut_u (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cur_l1(cur_l1), .cur_l2(cur_l2),
    .cur_l3(cur_l3), .volt_u1(volt_u1), .volt_u2(volt_u2), .volt_u3(volt_u3), .volt_u4(volt_u4),
    .block_in(block_in), .group_sel(group_sel), .stage_start(stage_start), .stage_trip(stage_trip),
    .stage_blocked(stage_blocked), .irq(irq), .evt_valid(evt_valid), .evt_flags(evt_flags),
    .evt_stamp(evt_stamp));
  aes_meas_model meas_u (.ref_clk(ref_clk), .cur_l1(cur_l1), .cur_l2(cur_l2), .cur_l3(cur_l3),
    .volt_u1(volt_u1), .volt_u2(volt_u2), .volt_u3(volt_u3), .volt_u4(volt_u4), .block_in(block_in));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task end_of_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic logic [7:0] ga(input int g, input int f);
    return GRP_BASE + 8'(16 * g + 4 * f);
  endfunction : ga

  function automatic logic sig(input int s);
    return s == 0 ? stage_start : (s == 1 ? stage_trip : stage_blocked);
  endfunction : sig

  task cw(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cw

  task wt(input int s, input logic v, input int lim);
    n = 0;
    while (n < lim && sig(s) !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wt

  task t_def;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      for (int f = 0; f < 4; f++) begin
        ahb(1'b0, ga(g, f), 32'h0);
        chk(rd, 32'(RV[f]));
      end
    end
    ahb(1'b0, REG_EVSEL, 32'h0);
    chk(rd, 32'(EVSEL_RST));
    chk(32'(hresp), 32'h0);
    ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (int g = 0; g < NUM_GROUPS; g++) begin
      ahb(1'b1, ga(g, F_TACT), TA);
      ahb(1'b1, ga(g, F_TREL), TR);
    end
    ahb(1'b1, ga(1, F_ULIM), 32'h0BB8);
  endtask : t_def

  task t_arm;
    ahb(1'b1, REG_CNT_CLR, 32'h7);
    ahb(1'b1, REG_IST, 32'h3F);
    meas_u.set(16'h0FA0, 16'h0, 16'h0, 16'h0, 1'b0);
    wt(0, 1'b1, (TA + 3) * CC);
    chk(32'(n >= TA * CC && n <= (TA + 2) * CC), 32'h1);
    chk(32'({evt_valid, evt_flags}), 32'h41);
    m = evt_stamp;
    ahb(1'b0, REG_STAMP, 32'h0);
    chk(rd, 32'(m));
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h3F, 32'h11);
    ahb(1'b0, REG_CNT_START, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, REG_IST, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    ahb(1'b1, REG_IMASK, 32'h1);
    cw(2);
    chk(32'(irq), 32'h1);
    ahb(1'b1, REG_IST, 32'h1);
    cw(2);
    chk(32'(irq), 32'h0);
  endtask : t_arm

  task t_trip;
    meas_u.set(16'h0FA0, 16'h000A, 16'h000A, 16'h000A, 1'b0);
    wt(1, 1'b1, 3 * CC);
    chk(32'(stage_trip), 32'h1);
    meas_u.set(16'h0FA0, 16'h000A, 16'h0005, 16'h000A, 1'b0);
    wt(1, 1'b0, 3 * CC);
    chk(32'(stage_trip), 32'h0);
    ahb(1'b0, REG_CNT_TRIP, 32'h0);
    chk(rd, 32'h1);
    meas_u.set(16'h0FA0, 16'h000A, 16'h000A, 16'h000A, 1'b0);
    wt(1, 1'b1, 3 * CC);
    chk(32'(stage_trip), 32'h1);
  endtask : t_trip

  task t_rel;
    meas_u.set(16'h1770, 16'h0, 16'h0, 16'h0, 1'b0);
    cw(CC + 2);
    meas_u.set(16'h1770, 16'h000A, 16'h000A, 16'h000A, 1'b0);
    wt(1, 1'b1, 2 * CC + 2);
    chk(32'(stage_trip), 32'h1);
    m = CC + 2 + n;
    wt(0, 1'b0, (TR + 3) * CC);
    m = m + n;
    chk(32'(m >= (TR - 1) * CC && m <= (TR + 3) * CC), 32'h1);
    cw(CC);
    chk(32'(stage_trip), 32'h0);
  endtask : t_rel

  task t_blk;
    meas_u.set(16'h0FA0, 16'h0, 16'h0, 16'h0, 1'b0);
    wt(0, 1'b1, (TA + 3) * CC);
    meas_u.set(16'h0FA0, 16'h000A, 16'h000A, 16'h000A, 1'b1);
    wt(2, 1'b1, 3 * CC);
    chk(32'({stage_blocked, stage_start}), 32'h2);
    cw(3 * CC);
    chk(32'(stage_trip), 32'h0);
    meas_u.set(16'h1770, 16'h0, 16'h0, 16'h0, 1'b0);
    cw((TR + 3) * CC);
    chk(32'({stage_blocked, stage_start}), 32'h0);
    ahb(1'b0, REG_CNT_BLOCK, 32'h0);
    chk(rd, 32'h1);
    meas_u.set(16'h0FA0, 16'h0, 16'h0, 16'h0, 1'b1);
    cw((TA + 3) * CC);
    chk(32'({stage_blocked, stage_start}), 32'h2);
    meas_u.set(16'h1770, 16'h0, 16'h0, 16'h0, 1'b0);
    cw((TR + 3) * CC);
  endtask : t_blk

  task t_grp;
    meas_u.set(16'h0FA0, 16'h0, 16'h0, 16'h0, 1'b0);
    wt(0, 1'b1, (TA + 3) * CC);
    @(posedge ref_clk);
    group_sel <= 1'b1;
    wt(0, 1'b0, (TR + 4) * CC);
    chk(32'(stage_start), 32'h0);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, ga(1, F_ULIM), 32'h1388);
    wt(0, 1'b1, (TA + 4) * CC);
    chk(32'(stage_start), 32'h1);
    @(posedge ref_clk);
    group_sel <= 1'b0;
  endtask : t_grp

  task t_mode;
    ahb(1'b1, REG_CTRL, 32'h2);
    cw(2 * CC + 2);
    chk(32'(stage_start), 32'h0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    ahb(1'b1, REG_CTRL, 32'h4);
    cw(2 * CC + 2);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h1);
    cw((TA + 3) * CC);
    chk(32'({stage_blocked, stage_start}), 32'h2);
    ahb(1'b1, REG_CTRL, 32'h3);
    cw(2 * CC + 2);
    chk(32'({stage_blocked, stage_trip, stage_start}), 32'h4);
    meas_u.set(16'h1770, 16'h0, 16'h0, 16'h0, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h0);
    cw((TR + 3) * CC);
    for (int f = 1; f < 4; f++) begin
      ahb(1'b1, REG_CTRL, 32'(f << 4));
      cw(2 * CC + 2);
      chk(32'({stage_blocked, stage_trip, stage_start}), 32'(FX[f - 1]));
    end
    ahb(1'b1, REG_CTRL, 32'h0);
    cw(2 * CC + 2);
    chk(32'({stage_blocked, stage_trip, stage_start}), 32'h0);
  endtask : t_mode

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    group_sel = 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_def();
    t_arm();
    t_trip();
    t_rel();
    t_blk();
    t_grp();
    t_mode();
    end_of_test();
  end
endmodule : testbench
